// ===== logic/cmcr_top.sv
// clock multiplier control register bank with serial host port and input selection
`timescale 1ns/10ps
module cmcr_top
    import cmcr_pkg::*;
#(
    parameter int unsigned CAL_CYCLES = CAL_TIME_MS * (CLK_HZ / 1000),
    parameter logic [11:0] PART_IDENT = 12'h5a3,  // arbitrary value
    parameter logic [3:0]  REVISION   = 4'h1      // arbitrary value
) (
    // system
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // serial host link
    input  wire logic        spi_sclk,
    input  wire logic        spi_ss_n,
    input  wire logic        spi_sdi,
    output logic             spi_sdo,
    output logic             spi_sdo_oe,
    // clock monitor and select pins
    input  wire logic        input_select_pin,
    input  wire logic        in1_loss,
    input  wire logic        in2_loss,
    input  wire logic        in1_offset,
    input  wire logic        in2_offset,
    // loop control
    output logic             bypass_en,
    output logic             dco_freeze,
    output logic             active_input2,
    output logic             calibrating,
    output logic             calibrated,
    output logic [3:0]       loop_bandwidth_code,
    output logic [2:0]       offset_alarm_reference,
    // output buffers
    output logic [1:0]       cmos_drive_strength,
    output logic [2:0]       out1_format,
    output logic [2:0]       out2_format,
    output logic [1:0]       out1_static_hold,
    output logic [1:0]       out2_static_hold,
    output logic             out1_enable,
    output logic             out2_enable,
    output logic             out2_powerdown,
    // dividers
    output logic [2:0]       hs_divider,
    output logic [19:0]      out1_divider,
    output logic [19:0]      out2_divider,
    output logic [19:0]      fb_divider,
    output logic [18:0]      in1_divider,
    output logic [18:0]      in2_divider
);

    localparam int unsigned NSYNC = 6;

    // ---------------- link domain ----------------
    logic [4:0]            bit_cnt_q;
    logic [22:0]           shift_q;
    logic [FRAME_BITS-1:0] frame_q;
    logic                  frame_tog_q;
    logic                  sdo_q;
    logic [7:0]            readback_q;

    wire frame_last = (bit_cnt_q == FRAME_LAST);
    wire [4:0] rb_pos = FRAME_LAST - bit_cnt_q;
    wire rb_bit = (bit_cnt_q >= DATA_FIRST) ? readback_q[rb_pos[2:0]] : 1'b0;

    // counter restarts with every select, so a stopped clock leaves nothing half done
    always_ff @(posedge spi_sclk or posedge spi_ss_n) begin
        if (spi_ss_n) begin
            bit_cnt_q <= '0;
            shift_q   <= '0;
        end else begin
            bit_cnt_q <= frame_last ? 5'h00 : bit_cnt_q + 5'h01;
            shift_q   <= {shift_q[21:0], spi_sdi};
        end
    end

    // frame word held stable until the next frame; the toggle tells the system side
    always_ff @(posedge spi_sclk or negedge rst_n) begin
        if (!rst_n) begin
            frame_q     <= '0;
            frame_tog_q <= 1'b0;
        end else if (frame_last) begin
            frame_q     <= {shift_q, spi_sdi};
            frame_tog_q <= ~frame_tog_q;
        end
    end

    // readback is quiet while a frame runs, since it only moves after a read frame ends
    always_ff @(negedge spi_sclk or posedge spi_ss_n) begin
        if (spi_ss_n) begin
            sdo_q <= 1'b0;
        end else begin
            sdo_q <= rb_bit;
        end
    end

    assign spi_sdo    = sdo_q;
    assign spi_sdo_oe = ~spi_ss_n;

    // ---------------- synchronisers ----------------
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    wire  [NSYNC-1:0] sync_in = {frame_tog_q, input_select_pin, in2_offset, in1_offset,
                                 in2_loss, in1_loss};

    for (genvar g = 0; g < NSYNC; g++) begin : g_sync
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                sync1_q[g] <= 1'b0;
                sync2_q[g] <= 1'b0;
            end else begin
                sync1_q[g] <= sync_in[g];
                sync2_q[g] <= sync1_q[g];
            end
        end
    end

    wire [1:0] loss_s  = sync2_q[1:0];
    wire [1:0] ofs_s   = sync2_q[3:2];
    wire       pin_s   = sync2_q[4];
    wire       tog_s   = sync2_q[5];

    // ---------------- host access decode ----------------
    logic        tog_seen_q;
    logic [7:0]  regs_q [0:REG_COUNT-1];
    logic [1:0]  loss_flag_q;
    logic [1:0]  ofs_flag_q;

    wire       req    = tog_s ^ tog_seen_q;
    wire       is_rd  = frame_q[FR_RD_BIT];
    wire [7:0] addr   = frame_q[FR_ADDR_HI:FR_ADDR_LO];
    wire [7:0] wdata  = frame_q[7:0];
    wire       wr     = req & ~is_rd;
    wire       rd     = req & is_rd;
    wire [7:0] wmask  = cmcr_wmask(addr);
    wire       soft_rst  = wr & (addr == A_RST_CAL) & wdata[B_SOFT_RST];
    wire       cal_start = wr & (addr == A_RST_CAL) & wdata[B_CAL_START];
    wire       clr_loss  = wr & (addr == A_LOSS_STICKY);
    wire       clr_ofs   = wr & (addr == A_OFS_STICKY);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tog_seen_q <= 1'b0;
        end else begin
            tog_seen_q <= tog_s;
        end
    end

    // masked merge keeps read-only and reserved bits at their reset values
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < REG_COUNT; i++) begin
            if (!rst_n || soft_rst) begin
                regs_q[i] <= cmcr_rstval(8'(i));
            end else if (wr && addr == 8'(i)) begin
                regs_q[i] <= (regs_q[i] & ~wmask) | (wdata & wmask);
            end
        end
    end

    // field views
    wire       force_en   = regs_q[A_OUT_EN_BYP][B_FORCE_EN];
    wire [1:0] prio1_code = regs_q[A_PRIORITY][1:0];
    wire [1:0] prio2_code = regs_q[A_PRIORITY][3:2];
    wire [1:0] man_code   = regs_q[A_MAN_SEL_SQ][7:6];
    wire       sq_cal     = regs_q[A_MAN_SEL_SQ][B_SQ_CAL];
    wire [1:0] method     = regs_q[A_SEL_METHOD][7:6];
    wire       pin_sel_en = regs_q[A_SEL_PIN_CFG][B_PIN_SEL_EN];
    wire [2:0] fmt1       = regs_q[A_OUT_FORMAT][2:0];
    wire [2:0] fmt2       = regs_q[A_OUT_FORMAT][5:3];

    // ---------------- input alarms and sticky flags ----------------
    wire [1:0] alarm = loss_s | ofs_s;

    // a new alarm beats a clear written in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n || soft_rst) begin
            loss_flag_q <= 2'b00;
            ofs_flag_q  <= 2'b00;
        end else begin
            loss_flag_q <= (loss_flag_q & ~({2{clr_loss}} & ~wdata[B_ALM2:B_ALM1])) | loss_s;
            ofs_flag_q  <= (ofs_flag_q & ~({2{clr_ofs}} & ~wdata[B_ALM2:B_ALM1])) | ofs_s;
        end
    end

    // ---------------- input selection ----------------
    cmcr_sel_t sel_q;
    cmcr_sel_t sel_d;

    function automatic logic pick_in2(input logic [1:0] code);
        pick_in2 = (code == IN_CODE_2);
    endfunction

    wire cur2      = (sel_q == SEL_IN2);
    wire man_want2 = pin_sel_en ? pin_s : pick_in2(man_code);
    wire p1_in2    = pick_in2(prio1_code);
    wire p2_in2    = pick_in2(prio2_code);
    wire cur_bad   = cur2 ? alarm[1] : alarm[0];
    wire oth_bad   = cur2 ? alarm[0] : alarm[1];
    wire nonrev2   = (cur_bad && !oth_bad) ? ~cur2 : cur2;
    wire p1_bad    = p1_in2 ? alarm[1] : alarm[0];
    wire p2_bad    = p2_in2 ? alarm[1] : alarm[0];
    wire revert2   = !p1_bad ? p1_in2 : (!p2_bad ? p2_in2 : cur2);

    logic want2;
    always_comb begin
        unique case (method)
            METH_MANUAL: want2 = man_want2;
            METH_NONREV: want2 = nonrev2;
            METH_REVERT: want2 = revert2;
            default:     want2 = cur2;
        endcase
        sel_d = want2 ? SEL_IN2 : SEL_IN1;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sel_q <= SEL_IN1;
        end else begin
            sel_q <= sel_d;
        end
    end

    // ---------------- calibration ----------------
    logic [CAL_W-1:0] cal_cnt_q;
    logic             cal_busy_q;
    logic             cal_done_q;
    logic [3:0]       bw_applied_q;

    // bandwidth code is sampled only when a calibration starts
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cal_cnt_q    <= '0;
            cal_busy_q   <= 1'b0;
            cal_done_q   <= 1'b0;
            bw_applied_q <= R_BANDWIDTH[7:4];
        end else if (cal_start) begin
            cal_cnt_q    <= CAL_W'(CAL_CYCLES - 1);
            cal_busy_q   <= 1'b1;
            bw_applied_q <= regs_q[A_BANDWIDTH][7:4];
        end else if (cal_busy_q) begin
            cal_cnt_q  <= cal_cnt_q - CAL_W'(1);
            cal_busy_q <= (cal_cnt_q != '0);
            cal_done_q <= cal_done_q | (cal_cnt_q == '0);
        end
    end

    // ---------------- output control ----------------
    // without force_en, squelched before the first calibration, and during a later one when asked
    wire out_ok = force_en | (cal_done_q & ~(cal_busy_q & sq_cal));
    wire en1_d  = out_ok & (fmt1 != FMT_DISABLE)
                  & ~regs_q[A_OUT_DISABLE][B_DSBL1] & ~regs_q[A_OUT_PDOWN][B_PD1];
    wire en2_d  = out_ok & (fmt2 != FMT_DISABLE)
                  & ~regs_q[A_OUT_DISABLE][B_DSBL2] & ~regs_q[A_OUT_PDOWN][B_PD2];

    logic en1_q;
    logic en2_q;
    logic freeze_q;

    // freeze follows the alarm on the input actually in use
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            en1_q    <= 1'b0;
            en2_q    <= 1'b0;
            freeze_q <= 1'b0;
        end else begin
            en1_q    <= en1_d;
            en2_q    <= en2_d;
            freeze_q <= cur_bad;
        end
    end

    // ---------------- read path ----------------
    function automatic logic [7:0] read_value(input logic [7:0] a);
        unique case (a)
            A_ACTIVE_STAT: read_value = {6'h00, cur2, ~cur2};
            A_LOSS_STAT:   read_value = {5'h00, loss_s, 1'b0};
            A_OFS_STAT:    read_value = {5'h00, ofs_s, 1'b0};
            A_LOSS_STICKY: read_value = {5'h00, loss_flag_q, 1'b0};
            A_OFS_STICKY:  read_value = {5'h00, ofs_flag_q, 1'b0};
            A_IDENT_HI:    read_value = PART_IDENT[11:4];
            A_IDENT_LO:    read_value = {PART_IDENT[3:0], REVISION};
            default:       read_value = (a < 8'(REG_COUNT)) ? regs_q[a] : 8'h00;
        endcase
    endfunction

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            readback_q <= 8'h00;
        end else if (rd) begin
            readback_q <= read_value(addr);
        end
    end

    // ---------------- outputs ----------------
    // bypass with a cmos output is left to the host to avoid
    assign bypass_en              = regs_q[A_OUT_EN_BYP][B_BYPASS];
    assign dco_freeze             = freeze_q;
    assign active_input2          = cur2;
    assign calibrating            = cal_busy_q;
    assign calibrated             = cal_done_q;
    assign loop_bandwidth_code    = bw_applied_q;
    assign offset_alarm_reference = regs_q[A_OFS_REF][2:0];
    assign cmos_drive_strength    = regs_q[A_CMOS_DRIVE][7:6];
    assign out1_format            = fmt1;
    assign out2_format            = fmt2;
    // hold codes go to the buffer, which changes state only at a clock low or high phase
    assign out1_static_hold       = regs_q[A_STATIC_HOLD][5:4];
    assign out2_static_hold       = regs_q[A_STATIC_HOLD][7:6];
    assign out1_enable            = en1_q;
    assign out2_enable            = en2_q;
    assign out2_powerdown         = regs_q[A_OUT_PDOWN][B_PD2];
    assign hs_divider             = regs_q[A_HS_DIV][7:5];
    assign out1_divider = {regs_q[A_OUT1_DIV][3:0], regs_q[A_OUT1_DIV+1], regs_q[A_OUT1_DIV+2]};
    assign out2_divider = {regs_q[A_OUT2_DIV][3:0], regs_q[A_OUT2_DIV+1], regs_q[A_OUT2_DIV+2]};
    assign fb_divider   = {regs_q[A_FB_DIV][3:0], regs_q[A_FB_DIV+1], regs_q[A_FB_DIV+2]};
    assign in1_divider  = {regs_q[A_IN1_DIV][2:0], regs_q[A_IN1_DIV+1], regs_q[A_IN1_DIV+2]};
    assign in2_divider  = {regs_q[A_IN2_DIV][2:0], regs_q[A_IN2_DIV+1], regs_q[A_IN2_DIV+2]};

endmodule

// ===== common/cmcr_pkg.sv
// package: register map, field positions, codes and timing for the clock multiplier control bank
package cmcr_pkg;

    // timing
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned CAL_TIME_MS   = 35;
    localparam int unsigned READY_TIME_MS = 10;
    localparam int unsigned CAL_W         = 24;

    // link frame: command byte, address byte, data byte, msb first
    localparam int unsigned FRAME_BITS = 24;
    localparam logic [4:0]  FRAME_LAST = 5'h17;
    localparam logic [4:0]  DATA_FIRST = 5'h10;
    localparam int unsigned FR_RD_BIT  = 23;
    localparam int unsigned FR_ADDR_HI = 15;
    localparam int unsigned FR_ADDR_LO = 8;

    // register offsets
    localparam int unsigned REG_COUNT = 144;
    localparam logic [7:0] A_OUT_EN_BYP   = 8'h00;
    localparam logic [7:0] A_PRIORITY     = 8'h01;
    localparam logic [7:0] A_BANDWIDTH    = 8'h02;
    localparam logic [7:0] A_MAN_SEL_SQ   = 8'h03;
    localparam logic [7:0] A_SEL_METHOD   = 8'h04;
    localparam logic [7:0] A_CMOS_DRIVE   = 8'h05;
    localparam logic [7:0] A_OUT_FORMAT   = 8'h06;
    localparam logic [7:0] A_OFS_REF      = 8'h07;
    localparam logic [7:0] A_STATIC_HOLD  = 8'h08;
    localparam logic [7:0] A_OUT_DISABLE  = 8'h0a;
    localparam logic [7:0] A_OUT_PDOWN    = 8'h0b;
    localparam logic [7:0] A_OFS_CFG      = 8'h13;
    localparam logic [7:0] A_ALM_PIN_EN   = 8'h14;
    localparam logic [7:0] A_SEL_PIN_CFG  = 8'h15;
    localparam logic [7:0] A_PIN_POL      = 8'h16;
    localparam logic [7:0] A_LOSS_MASK    = 8'h17;
    localparam logic [7:0] A_OFS_MASK     = 8'h18;
    localparam logic [7:0] A_HS_DIV       = 8'h19;
    localparam logic [7:0] A_OUT1_DIV     = 8'h1f;
    localparam logic [7:0] A_OUT2_DIV     = 8'h22;
    localparam logic [7:0] A_FB_DIV       = 8'h28;
    localparam logic [7:0] A_IN1_DIV      = 8'h2b;
    localparam logic [7:0] A_IN2_DIV      = 8'h2e;
    localparam logic [7:0] A_IN_RATE      = 8'h37;
    localparam logic [7:0] A_ACTIVE_STAT  = 8'h80;
    localparam logic [7:0] A_LOSS_STAT    = 8'h81;
    localparam logic [7:0] A_OFS_STAT     = 8'h82;
    localparam logic [7:0] A_LOSS_STICKY  = 8'h83;
    localparam logic [7:0] A_OFS_STICKY   = 8'h84;
    localparam logic [7:0] A_IDENT_HI     = 8'h86;
    localparam logic [7:0] A_IDENT_LO     = 8'h87;
    localparam logic [7:0] A_RST_CAL      = 8'h88;
    localparam logic [7:0] A_LOSS_DET_A   = 8'h8a;
    localparam logic [7:0] A_ALM_DET_B    = 8'h8b;
    localparam logic [7:0] A_SKEW1        = 8'h8e;
    localparam logic [7:0] A_SKEW2        = 8'h8f;

    // reset values
    localparam logic [7:0] R_OUT_EN_BYP  = 8'h14;
    localparam logic [7:0] R_PRIORITY    = 8'he4;
    localparam logic [7:0] R_BANDWIDTH   = 8'h42;
    localparam logic [7:0] R_MAN_SEL_SQ  = 8'h05;
    localparam logic [7:0] R_SEL_METHOD  = 8'h12;
    localparam logic [7:0] R_CMOS_DRIVE  = 8'hed;
    localparam logic [7:0] R_OUT_FORMAT  = 8'h2d;
    localparam logic [7:0] R_OFS_REF     = 8'h2a;
    localparam logic [7:0] R_DEFAULT     = 8'h00;

    // field positions
    localparam int unsigned B_FORCE_EN   = 5;
    localparam int unsigned B_BYPASS     = 1;
    localparam int unsigned B_SQ_CAL     = 4;
    localparam int unsigned B_PIN_SEL_EN = 0;
    localparam int unsigned B_DSBL1      = 2;
    localparam int unsigned B_DSBL2      = 3;
    localparam int unsigned B_PD1        = 0;
    localparam int unsigned B_PD2        = 1;
    localparam int unsigned B_ALM1       = 1;
    localparam int unsigned B_ALM2       = 2;
    localparam int unsigned B_SOFT_RST   = 7;
    localparam int unsigned B_CAL_START  = 6;

    // codes
    localparam logic [1:0] IN_CODE_2    = 2'h1;
    localparam logic [1:0] METH_MANUAL  = 2'h0;
    localparam logic [1:0] METH_NONREV  = 2'h1;
    localparam logic [1:0] METH_REVERT  = 2'h2;
    localparam logic [2:0] FMT_DISABLE  = 3'h1;

    typedef enum logic [1:0] {
        SEL_IN1 = 2'b01,
        SEL_IN2 = 2'b10
    } cmcr_sel_t;

    // bits that host writes may change; zero marks read-only or unmapped
    function automatic logic [7:0] cmcr_wmask(input logic [7:0] a);
        unique case (a)
            A_OUT_EN_BYP:                          cmcr_wmask = 8'h22;
            A_PRIORITY:                            cmcr_wmask = 8'h0f;
            A_BANDWIDTH:                           cmcr_wmask = 8'hf0;
            A_MAN_SEL_SQ:                          cmcr_wmask = 8'hd0;
            A_SEL_METHOD, A_CMOS_DRIVE:            cmcr_wmask = 8'hc0;
            A_OUT_FORMAT:                          cmcr_wmask = 8'h3f;
            A_OFS_REF:                             cmcr_wmask = 8'h07;
            A_STATIC_HOLD:                         cmcr_wmask = 8'hf0;
            A_OUT_DISABLE:                         cmcr_wmask = 8'h0c;
            A_OUT_PDOWN:                           cmcr_wmask = 8'h03;
            A_HS_DIV:                              cmcr_wmask = 8'he0;
            A_OUT1_DIV, A_OUT2_DIV, A_FB_DIV:      cmcr_wmask = 8'h0f;
            A_IN1_DIV, A_IN2_DIV:                  cmcr_wmask = 8'h07;
            A_IN_RATE:                             cmcr_wmask = 8'h3f;
            A_OFS_CFG, A_ALM_PIN_EN, A_SEL_PIN_CFG, A_PIN_POL, A_LOSS_MASK, A_OFS_MASK,
            8'h20, 8'h21, 8'h23, 8'h24, 8'h29, 8'h2a, 8'h2c, 8'h2d, 8'h2f, 8'h30,
            A_LOSS_DET_A, A_ALM_DET_B, A_SKEW1, A_SKEW2: cmcr_wmask = 8'hff;
            default:                               cmcr_wmask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] cmcr_rstval(input logic [7:0] a);
        unique case (a)
            A_OUT_EN_BYP:  cmcr_rstval = R_OUT_EN_BYP;
            A_PRIORITY:    cmcr_rstval = R_PRIORITY;
            A_BANDWIDTH:   cmcr_rstval = R_BANDWIDTH;
            A_MAN_SEL_SQ:  cmcr_rstval = R_MAN_SEL_SQ;
            A_SEL_METHOD:  cmcr_rstval = R_SEL_METHOD;
            A_CMOS_DRIVE:  cmcr_rstval = R_CMOS_DRIVE;
            A_OUT_FORMAT:  cmcr_rstval = R_OUT_FORMAT;
            A_OFS_REF:     cmcr_rstval = R_OFS_REF;
            default:       cmcr_rstval = R_DEFAULT;
        endcase
    endfunction

endpackage

// ===== dv/cmcr_top_assertions.sv
// checker: port timing relations of the control bank
`timescale 1ns/10ps
module cmcr_top_assertions
    import cmcr_pkg::*;
#(
    parameter int unsigned CAL_CYCLES = 20
) (
    // system and link
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       spi_ss_n,
    input wire logic       spi_sdo_oe,
    input wire logic       spi_sdo,
    // alarms
    input wire logic       in1_loss,
    input wire logic       in2_loss,
    input wire logic       in1_offset,
    input wire logic       in2_offset,
    // loop and outputs
    input wire logic       dco_freeze,
    input wire logic       active_input2,
    input wire logic       calibrating,
    input wire logic       calibrated,
    input wire logic [3:0] loop_bandwidth_code,
    input wire logic [2:0] out1_format,
    input wire logic       out1_enable,
    input wire logic       out2_powerdown,
    input wire logic       out2_enable
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // counts calibration cycles; a restart mid-run would need a fresh count
    logic [31:0] cal_cnt_q;
    wire logic [31:0] cal_cnt_d = calibrating ? cal_cnt_q + 32'h1 : 32'h0;
    always_ff @(posedge clk_sys) begin
        cal_cnt_q <= rst_n ? cal_cnt_d : 32'h0;
    end

    // sync delay is three edges, so four cycles of cause is enough
    sequence s_in1_down;
        (in1_loss && !active_input2)[*4];
    endsequence
    sequence s_all_clean;
        (!(in1_loss || in2_loss || in1_offset || in2_offset))[*4];
    endsequence

    a_fmt_off_out1: assert property (out1_format == FMT_DISABLE |=> !out1_enable)
        else $error("out1 enabled while format disabled");
    a_pd_out2: assert property (out2_powerdown |=> !out2_enable)
        else $error("out2 enabled while powered down");
    a_freeze_on_alarm: assert property (s_in1_down |-> dco_freeze)
        else $error("oscillator not frozen on alarm");
    a_freeze_clean: assert property (s_all_clean |-> !dco_freeze)
        else $error("oscillator frozen without alarm");
    a_cal_length: assert property ($fell(calibrating) |-> cal_cnt_q == CAL_CYCLES)
        else $error("calibration length wrong");
    a_cal_done: assert property ($fell(calibrating) |-> calibrated)
        else $error("calibration end not flagged");
    a_bw_at_cal: assert property ($changed(loop_bandwidth_code) |-> calibrating)
        else $error("bandwidth changed outside calibration");
    a_sdo_idle: assert property (spi_ss_n |-> !spi_sdo_oe && !spi_sdo)
        else $error("sdo driven while deselected");
endmodule

bind cmcr_top cmcr_top_assertions #(.CAL_CYCLES(CAL_CYCLES)) u_chk (
    .clk_sys, .rst_n, .spi_ss_n, .spi_sdo_oe, .spi_sdo, .in1_loss, .in2_loss, .in1_offset,
    .in2_offset, .dco_freeze, .active_input2, .calibrating, .calibrated,
    .loop_bandwidth_code, .out1_format, .out1_enable, .out2_powerdown, .out2_enable
);

// ===== dv/cmcr_host_model.sv
// host model: serial frame master for the control bank link
`timescale 1ns/10ps
module cmcr_host_model (
    // link pins
    input  wire logic clk_sys,
    output logic      spi_sclk,
    output logic      spi_ss_n,
    output logic      spi_sdi,
    input  wire logic spi_sdo
);
    initial begin
        spi_sclk = 1'b0;
        spi_ss_n = 1'b1;
        spi_sdi  = 1'b0;
    end

    // one 24-bit frame; link clock runs only inside it, 15 ns period
    task automatic xfer(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        logic [23:0] w;
        w = {c, a, d};
        @(negedge clk_sys);
        spi_ss_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_sdi = w[i];
            #7.5 spi_sclk = 1'b1;
            q = {q[6:0], spi_sdo};
            #7.5 spi_sclk = 1'b0;
        end
        #7.5 spi_ss_n = 1'b1;
        // released line shows the inverse so a stale bit cannot pass
        spi_sdi = ~spi_sdi;
        // frame ends over 1 us apart, else the bank may drop one
        repeat (12) @(negedge clk_sys);
    endtask
endmodule

// ===== dv/clock_multiplier_control_regs_tb_top.sv
// testbench: register, calibration, output and selection scenarios
`timescale 1ns/10ps
module clock_multiplier_control_regs_tb_top;
    import cmcr_pkg::*;
    localparam int unsigned CAL_SIM = 20;
    logic        clk_sys = 1'b0;
    logic        rst_n, input_select_pin, in1_loss, in2_loss, in1_offset, in2_offset;
    logic        spi_sclk, spi_ss_n, spi_sdi, spi_sdo, spi_sdo_oe;
    logic        bypass_en, dco_freeze, active_input2, calibrating, calibrated;
    logic        out1_enable, out2_enable, out2_powerdown;
    logic [3:0]  loop_bandwidth_code;
    logic [2:0]  offset_alarm_reference, out1_format, out2_format, hs_divider;
    logic [1:0]  cmos_drive_strength, out1_static_hold, out2_static_hold;
    logic [19:0] out1_divider, out2_divider, fb_divider;
    logic [18:0] in1_divider, in2_divider;
    logic [7:0]  rst_tbl [9] = '{8'h14, 8'he4, 8'h42, 8'h05, 8'h12, 8'hed, 8'h2d, 8'h2a, 8'h00};
    int          miscompares = 0;
    int          n_compared = 0;

    always #50 clk_sys = ~clk_sys;

    cmcr_top #(.CAL_CYCLES(CAL_SIM)) dut (.*);
    cmcr_host_model host (.clk_sys(clk_sys), .spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n),
                          .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.xfer(8'h00, a, d, q);
    endtask
    // readback arrives in the following frame
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        host.xfer(8'h80, a, 8'h00, q);
        host.xfer(8'h80, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic final_report;
        if (miscompares == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #2_000_000;
        miscompares++;
        final_report();
    end

    initial begin
        {rst_n, input_select_pin, in1_loss, in2_loss, in1_offset, in2_offset} = 6'h00;
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (20) @(negedge clk_sys);
        for (int i = 0; i < 9; i++) rd(i[7:0], rst_tbl[i]);
        rd(8'h40, 8'h00);
        wr(8'h00, 8'h36);
        wr(8'h80, 8'h02);
        rd(8'h00, 8'h36);
        rd(8'h80, 8'h01);
        chk(bypass_en, 1'b1);
        wr(8'h00, 8'h14);
        wr(8'h02, 8'h72);
        chk({loop_bandwidth_code, out1_enable}, {4'h4, 1'b0});
        wr(8'h88, 8'h40);
        chk(calibrating, 1'b1);
        repeat (CAL_SIM) @(negedge clk_sys);
        chk({calibrated, loop_bandwidth_code, out1_enable, out2_enable},
            {1'b1, 4'h7, 1'b1, 1'b1});
        wr(8'h03, 8'h15);
        wr(8'h88, 8'h40);
        chk(out1_enable, 1'b0);
        repeat (CAL_SIM) @(negedge clk_sys);
        chk(out1_enable, 1'b1);
        wr(8'h00, 8'h34);
        wr(8'h88, 8'h40);
        chk(out1_enable, 1'b1);
        wr(8'h0b, 8'h02);
        chk(out2_enable, 1'b0);
        wr(8'h06, 8'h29);
        chk({out1_format, out2_format, out1_enable}, {3'h1, 3'h5, 1'b0});
        in1_loss = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk({dco_freeze, active_input2}, 2'b10);
        rd(8'h83, 8'h02);
        wr(8'h04, 8'h92);
        chk({dco_freeze, active_input2}, 2'b01);
        in1_loss = 1'b0;
        repeat (6) @(negedge clk_sys);
        chk(active_input2, 1'b0);
        wr(8'h04, 8'h52);
        in1_loss = 1'b1;
        repeat (6) @(negedge clk_sys);
        in1_loss = 1'b0;
        repeat (6) @(negedge clk_sys);
        chk(active_input2, 1'b1);
        wr(8'h04, 8'h12);
        wr(8'h03, 8'h15);
        wr(8'h15, 8'h01);
        input_select_pin = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk(active_input2, 1'b1);
        wr(8'h15, 8'h00);
        rd(8'h80, 8'h01);
        wr(8'h03, 8'h55);
        chk(active_input2, 1'b1);
        wr(8'h07, 8'h29);
        wr(8'h05, 8'h2d);
        wr(8'h08, 8'h90);
        chk({offset_alarm_reference, cmos_drive_strength}, {3'h1, 2'h0});
        chk({out1_static_hold, out2_static_hold}, {2'h1, 2'h2});
        wr(8'h1f, 8'h0a);
        wr(8'h20, 8'hbc);
        wr(8'h21, 8'hde);
        wr(8'h30, 8'h5a);
        wr(8'h19, 8'ha0);
        chk(out1_divider, 20'habcde);
        chk(in2_divider, 19'h0005a);
        chk(in1_divider, 19'h00000);
        chk(hs_divider, 3'h5);
        // soft reset brings registers and sticky flags back, not calibration
        wr(8'h88, 8'h80);
        rd(8'h83, 8'h00);
        rd(8'h06, 8'h2d);
        chk(active_input2, 1'b0);
        final_report();
    end
endmodule
